// ==== hw/sp_pkg.sv ====
// Purpose: Shared constants and types for the dual mode serial port.
// Assumes: 8-bit registers, one per aligned 32-bit word.
// Notes: Offsets are byte addresses on the register bus.
package sp_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFS_TXCS = 8'h00;
	localparam logic [7:0] OFS_RXCS = 8'h04;
	localparam logic [7:0] OFS_DIV = 8'h08;
	localparam logic [7:0] OFS_LAT = 8'h0C;
	localparam logic [7:0] OFS_TXD = 8'h10;
	localparam logic [7:0] OFS_RXD = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	// Transmit control and status bit positions.
	localparam int TXB_CLOCK_SOURCE_SELECT = 7;
	localparam int TXB_TX9 = 6;
	localparam int TXB_TRANSMIT_ENABLE_BIT = 5;
	localparam int TXB_SYNC = 4;
	localparam int TXB_HIGH_SPEED_SELECT = 2;
	localparam int TXB_TX_NINTH_BIT = 0;
	// Receive control and status bit positions.
	localparam int RXB_PORT_ENABLE = 7;
	localparam int RXB_RX9 = 6;
	localparam int RXB_SINGLE_RECEIVE_ENABLE = 5;
	localparam int RXB_CONTINUOUS_RECEIVE_ENABLE = 4;
	localparam int RXB_ADDRESS_DETECT_ENABLE = 3;
	// Open-drain select position in the port latch register.
	localparam int LATB_OD = 7;
	// Baud ticks per asynchronous bit, minus one, and mid-bit tick.
	localparam logic [5:0] TPB_HI_M1 = 6'h0F;
	localparam logic [5:0] TPB_LO_M1 = 6'h3F;
	localparam logic [5:0] MID_HI = 6'h08;
	localparam logic [5:0] MID_LO = 6'h20;
	// Synchronous clock phases: high in 0 and 1, low in 2 and 3.
	localparam logic [1:0] PH_HIGH_END = 2'h1;
	localparam logic [1:0] PH_LAST = 2'h3;
	// Character lengths and bus responses.
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SYNC} rx_state_t;
	// Whole state of the port, registered as one word.
	typedef struct packed {
		logic aw_got, w_got, w_stb, awready, wready, bvalid, arready, rvalid;
		logic [7:0] aw_addr, w_data, rdata;
		logic [1:0] bresp, rresp;
		logic clock_source_select, tx9, transmit_enable_bit, sync, high_speed_select, tx_ninth_bit, port_enable, rx9, single_receive_enable, continuous_receive_enable, address_detect_enable, od;
		logic [7:0] div, baud_generator, rx_buf, tx_hold;
		logic framing_error_flag, overrun_error_flag, rx_ninth_bit, rx_full, tx_hold_full;
		tx_state_t txs;
		logic [10:0] tx_sh;
		logic [3:0] tx_bits, rx_bits;
		logic [5:0] tx_tick, rx_tick;
		rx_state_t rxs;
		logic [8:0] rx_sh;
		logic [1:0] votes, phase;
		logic ck_s1, ck_s2, ck_prev, dt_s1, dt_s2, ck_gen;
		logic ck_o, ck_oe, dt_o, dt_oe;
	} state_t;
endpackage

// ==== hw/dual_mode_serial_port_ctrl.sv ====
// Purpose: Serial port with async, sync master and sync slave modes.
// Assumes: AXI4-Lite register access, pins sampled on aclk.
// Notes: Port enable low holds the engines and flags in reset.
// Summary of operation
// - Async, sync master and sync slave modes.
// - Pin directions follow the current operation.
// - Open-drain select makes transmit pin open-drain.
// - Clock source selects master or slave clocking.
// - Transmit nine-bit select sets character length.
// - Transmit enable; sync receive overrides it.
// - Mode bit selects sync or async.
// - High speed select affects async only.
// - Shift empty flag reads one after reset.
// - Transmit ninth bit supplies ninth bit.
// - Port enable off holds port in reset.
// - Receive nine-bit select sets character length.
// - Single receive clears itself when done.
// - Continuous receive enables, overrides single.
// - Address detect accepts ninth-bit-set characters.
// - Framing error cleared by next valid byte.
// - Overrun cleared by clearing continuous receive.
// - Ninth received bit stored, no parity check.
// - Divisor write restarts the baud timer.
// - Async receive level is majority of three; sync receive takes one sample.
`timescale 1ns/1ps
module dual_mode_serial_port_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic transmit_clock_pin_in,
	output logic transmit_clock_pin_out,
	output logic transmit_clock_pin_oe,
	input wire logic receive_data_pin_in,
	output logic receive_data_pin_out,
	output logic receive_data_pin_oe
);
	sp_pkg::state_t s; // Registered state.
	sp_pkg::state_t n; // Next state.
	logic tick; // Baud generator pulse.
	logic rise; // Sync clock rising edge.
	logic fall; // Sync clock falling edge.
	logic rx_done; // A character finished.
	logic stop_bad; // Stop bit was low.
	logic [8:0] rx_word; // Finished shift contents.
	logic div_wr; // Divisor written.
	logic ovr_set; // Overrun event.
	logic overrun_error_flag_clr; // Continuous receive cleared by a write.
	logic rd_rx; // Receive buffer read.
	logic bitv; // Voted bit value.
	logic master; // Sync master mode.
	logic rx_en; // Sync receive enabled.
	logic run; // Master clock running.
	logic tx_line; // Async transmit line level.
	logic ck_val; // Value for the clock pin.
	logic ck_en; // Drive for the clock pin.
	logic hold_wr; // Transmit data written in this cycle.

	// Character length in data bits.
	function automatic logic [3:0] nbits(input logic nine);
		return nine ? sp_pkg::BITS_NINE : sp_pkg::BITS_EIGHT;
	endfunction

	// Baud ticks per async bit, minus one.
	function automatic logic [5:0] tpb_m1(input logic hi);
		return hi ? sp_pkg::TPB_HI_M1 : sp_pkg::TPB_LO_M1;
	endfunction

	// Majority of two stored samples and the current one.
	function automatic logic maj(input logic [1:0] v, input logic b);
		return ({1'b0, v} + {2'b00, b}) >= 3'h2;
	endfunction

	// True for an implemented register offset.
	function automatic logic mapped(input logic [7:0] a);
		return a inside {sp_pkg::OFS_TXCS, sp_pkg::OFS_RXCS, sp_pkg::OFS_DIV, sp_pkg::OFS_LAT,
			sp_pkg::OFS_TXD, sp_pkg::OFS_RXD, sp_pkg::OFS_STAT};
	endfunction

	// Read value of a register; unimplemented bits read zero.
	function automatic logic [7:0] reg_read(input logic [7:0] a, input sp_pkg::state_t st);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			sp_pkg::OFS_TXCS: v = {st.clock_source_select, st.tx9, st.transmit_enable_bit, st.sync, 1'b0, st.high_speed_select,
				st.txs == sp_pkg::TX_IDLE, st.tx_ninth_bit};
			sp_pkg::OFS_RXCS: v = {st.port_enable, st.rx9, st.single_receive_enable, st.continuous_receive_enable, st.address_detect_enable, st.framing_error_flag, st.overrun_error_flag, st.rx_ninth_bit};
			sp_pkg::OFS_DIV: v = st.div;
			sp_pkg::OFS_LAT: v = {st.od, 7'h00};
			sp_pkg::OFS_RXD: v = st.rx_buf;
			sp_pkg::OFS_STAT: v = {6'h00, !st.tx_hold_full, st.rx_full};
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Next-state logic for bus, baud generator, engines and pins.
	always_comb begin
		n = s;
		tick = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		rx_done = 1'b0;
		stop_bad = 1'b0;
		rx_word = s.rx_sh;
		div_wr = 1'b0;
		ovr_set = 1'b0;
		overrun_error_flag_clr = 1'b0;
		rd_rx = 1'b0;
		bitv = 1'b0;
		run = 1'b0;
		tx_line = 1'b1;
		ck_val = 1'b0;
		ck_en = 1'b0;
		hold_wr = 1'b0;
		// Two-stage synchronisers on both pins.
		n.ck_s1 = transmit_clock_pin_in;
		n.ck_s2 = s.ck_s1;
		n.ck_prev = s.ck_s2;
		n.dt_s1 = receive_data_pin_in;
		n.dt_s2 = s.dt_s1;
		// Write address and data are taken independently.
		if (awvalid && s.awready) begin
			n.aw_got = 1'b1;
			n.aw_addr = awaddr;
		end
		if (wvalid && s.wready) begin
			n.w_got = 1'b1;
			n.w_data = wdata[7:0];
			n.w_stb = wstrb[0];
		end
		if (s.bvalid && bready) begin
			n.bvalid = 1'b0;
		end
		// Both halves present: perform the write and answer.
		if (n.aw_got && n.w_got && !s.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = mapped(n.aw_addr) ? sp_pkg::RESP_OKAY : sp_pkg::RESP_SLVERR;
			if (n.w_stb) begin
				case (n.aw_addr)
					sp_pkg::OFS_TXCS: begin
						n.clock_source_select = n.w_data[sp_pkg::TXB_CLOCK_SOURCE_SELECT];
						n.tx9 = n.w_data[sp_pkg::TXB_TX9];
						n.transmit_enable_bit = n.w_data[sp_pkg::TXB_TRANSMIT_ENABLE_BIT];
						n.sync = n.w_data[sp_pkg::TXB_SYNC];
						n.high_speed_select = n.w_data[sp_pkg::TXB_HIGH_SPEED_SELECT];
						n.tx_ninth_bit = n.w_data[sp_pkg::TXB_TX_NINTH_BIT];
					end
					sp_pkg::OFS_RXCS: begin
						n.port_enable = n.w_data[sp_pkg::RXB_PORT_ENABLE];
						n.rx9 = n.w_data[sp_pkg::RXB_RX9];
						n.single_receive_enable = n.w_data[sp_pkg::RXB_SINGLE_RECEIVE_ENABLE];
						n.continuous_receive_enable = n.w_data[sp_pkg::RXB_CONTINUOUS_RECEIVE_ENABLE];
						n.address_detect_enable = n.w_data[sp_pkg::RXB_ADDRESS_DETECT_ENABLE];
						overrun_error_flag_clr = !n.w_data[sp_pkg::RXB_CONTINUOUS_RECEIVE_ENABLE];
					end
					sp_pkg::OFS_DIV: begin
						n.div = n.w_data;
						div_wr = 1'b1;
					end
					sp_pkg::OFS_LAT: n.od = n.w_data[sp_pkg::LATB_OD];
					sp_pkg::OFS_TXD: begin
						n.tx_hold = n.w_data;
						n.tx_hold_full = 1'b1;
						hold_wr = 1'b1;
					end
					default: n.od = s.od;
				endcase
			end
		end
		// Reads answer in the next cycle; buffer read frees it.
		if (s.rvalid && rready) begin
			n.rvalid = 1'b0;
		end
		if (arvalid && s.arready) begin
			n.rvalid = 1'b1;
			n.rresp = mapped(araddr) ? sp_pkg::RESP_OKAY : sp_pkg::RESP_SLVERR;
			n.rdata = reg_read(araddr, s);
			rd_rx = araddr == sp_pkg::OFS_RXD;
		end
		n.awready = !n.aw_got && !n.bvalid;
		n.wready = !n.w_got && !n.bvalid;
		n.arready = !n.rvalid;
		// Baud generator reloads on divisor write.
		tick = s.port_enable && s.baud_generator == 8'h00;
		if (!s.port_enable || div_wr || tick) begin
			n.baud_generator = n.div;
		end else begin
			n.baud_generator = s.baud_generator - 8'h01;
		end
		// Mode decode; single receive only counts in master.
		master = s.sync && s.clock_source_select;
		rx_en = s.sync && (s.continuous_receive_enable || (s.single_receive_enable && s.clock_source_select));
		// Sync clock edges from own divider or from the pin.
		if (master) begin
			run = rx_en || s.txs == sp_pkg::TX_SYNC;
			if (!run) begin
				n.phase = sp_pkg::PH_LAST;
				n.ck_gen = 1'b0;
			end else if (tick) begin
				n.phase = s.phase + 2'h1;
				n.ck_gen = !n.phase[1];
				rise = s.phase == sp_pkg::PH_LAST;
				fall = s.phase == sp_pkg::PH_HIGH_END;
			end
		end else begin
			rise = s.ck_s2 && !s.ck_prev;
			fall = !s.ck_s2 && s.ck_prev;
		end
		// Transmitter.
		unique case (s.txs)
			sp_pkg::TX_IDLE: begin
				if (s.transmit_enable_bit && s.tx_hold_full && !rx_en) begin
					// A word written in this very cycle stays pending, so the write wins.
					n.tx_hold_full = hold_wr;
					n.tx_bits = 4'h0;
					n.tx_tick = 6'h00;
					if (s.sync) begin
						n.tx_sh = {2'b11, s.tx_ninth_bit, s.tx_hold};
						n.txs = sp_pkg::TX_SYNC;
					end else begin
						n.tx_sh = {1'b1, s.tx9 ? s.tx_ninth_bit : 1'b1, s.tx_hold, 1'b0};
						n.txs = sp_pkg::TX_ASYNC;
					end
				end
			end
			sp_pkg::TX_ASYNC: begin
				if (tick) begin
					if (s.tx_tick == tpb_m1(s.high_speed_select)) begin
						n.tx_tick = 6'h00;
						n.tx_sh = {1'b1, s.tx_sh[10:1]};
						n.tx_bits = s.tx_bits + 4'h1;
						if (s.tx_bits == nbits(s.tx9) + 4'h1) begin
							n.txs = sp_pkg::TX_IDLE;
						end
					end else begin
						n.tx_tick = s.tx_tick + 6'h01;
					end
				end
			end
			sp_pkg::TX_SYNC: begin
				if (rx_en) begin
					n.txs = sp_pkg::TX_IDLE;
				end else if (s.tx_bits == nbits(s.tx9)) begin
					// The last bit stands one clock past its fall, so the far side still sees it.
					n.txs = sp_pkg::TX_IDLE;
				end else if (fall) begin
					n.tx_bits = s.tx_bits + 4'h1;
				end else if (rise && s.tx_bits != 4'h0) begin
					n.tx_sh = {1'b1, s.tx_sh[10:1]};
				end
			end
		endcase
		// Receiver.
		unique case (s.rxs)
			sp_pkg::RX_IDLE: begin
				n.rx_bits = 4'h0;
				n.rx_tick = 6'h00;
				n.votes = 2'h0;
				if (!s.sync && s.continuous_receive_enable && !s.dt_s2) begin
					n.rxs = sp_pkg::RX_ASYNC;
				end else if (rx_en) begin
					n.rxs = sp_pkg::RX_SYNC;
				end
			end
			sp_pkg::RX_ASYNC: begin
				if (!s.continuous_receive_enable || s.sync) begin
					n.rxs = sp_pkg::RX_IDLE;
				end else if (tick) begin
					n.rx_tick = s.rx_tick + 6'h01;
					if (s.rx_tick == tpb_m1(s.high_speed_select)) begin
						n.rx_tick = 6'h00;
						n.rx_bits = s.rx_bits + 4'h1;
					end
					if (s.rx_tick == (s.high_speed_select ? sp_pkg::MID_HI : sp_pkg::MID_LO) - 6'h01 ||
						s.rx_tick == (s.high_speed_select ? sp_pkg::MID_HI : sp_pkg::MID_LO)) begin
						n.votes = s.votes + {1'b0, s.dt_s2};
					end
					if (s.rx_tick == (s.high_speed_select ? sp_pkg::MID_HI : sp_pkg::MID_LO) + 6'h01) begin
						bitv = maj(s.votes, s.dt_s2);
						n.votes = 2'h0;
						if (s.rx_bits == 4'h0) begin
							if (bitv) begin
								n.rxs = sp_pkg::RX_IDLE;
							end
						end else if (s.rx_bits <= nbits(s.rx9)) begin
							n.rx_sh = {bitv, s.rx_sh[8:1]};
						end else begin
							rx_done = 1'b1;
							stop_bad = !bitv;
							n.rxs = sp_pkg::RX_IDLE;
						end
					end
				end
			end
			sp_pkg::RX_SYNC: begin
				if (!rx_en) begin
					n.rxs = sp_pkg::RX_IDLE;
				end else if (fall) begin
					rx_word = {s.dt_s2, s.rx_sh[8:1]};
					n.rx_sh = rx_word;
					n.rx_bits = s.rx_bits + 4'h1;
					if (s.rx_bits == nbits(s.rx9) - 4'h1) begin
						rx_done = 1'b1;
						n.rxs = sp_pkg::RX_IDLE;
						if (master) begin
							n.single_receive_enable = 1'b0;
						end
					end
				end
			end
		endcase
		// Buffer load, address filter and overrun.
		if (rd_rx) begin
			n.rx_full = 1'b0;
		end
		if (rx_done) begin
			if (!s.sync && s.rx9 && s.address_detect_enable && !rx_word[8]) begin
				n.rx_full = n.rx_full;
			end else if (s.rx_full && !rd_rx) begin
				ovr_set = 1'b1;
			end else begin
				n.rx_full = 1'b1;
				n.rx_buf = s.rx9 ? rx_word[7:0] : rx_word[8:1];
				n.rx_ninth_bit = s.rx9 && rx_word[8];
				n.framing_error_flag = stop_bad;
			end
		end
		n.overrun_error_flag = ovr_set || (s.overrun_error_flag && !overrun_error_flag_clr);
		// Disabled port: engines and flags held in reset.
		if (!s.port_enable) begin
			n.txs = sp_pkg::TX_IDLE;
			n.rxs = sp_pkg::RX_IDLE;
			n.tx_hold_full = 1'b0;
			n.rx_full = 1'b0;
			n.framing_error_flag = 1'b0;
			n.overrun_error_flag = 1'b0;
			n.phase = sp_pkg::PH_LAST;
			n.ck_gen = 1'b0;
		end
		// Pin ownership follows mode and activity.
		if (n.txs == sp_pkg::TX_ASYNC) begin
			tx_line = n.tx_sh[0];
		end
		if (!s.sync) begin
			ck_en = s.port_enable && s.transmit_enable_bit;
			ck_val = tx_line;
		end else if (master) begin
			ck_en = s.port_enable;
			ck_val = n.ck_gen;
		end
		n.ck_o = s.od ? 1'b0 : ck_val;
		n.ck_oe = s.od ? (ck_en && !ck_val) : ck_en;
		n.dt_oe = s.port_enable && s.sync && n.txs == sp_pkg::TX_SYNC;
		n.dt_o = n.tx_sh[0];
	end

	// State register with synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Outputs come straight from the state register.
	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rresp = s.rresp;
	assign rdata = {24'h000000, s.rdata};
	assign transmit_clock_pin_out = s.ck_o;
	assign transmit_clock_pin_oe = s.ck_oe;
	assign receive_data_pin_out = s.dt_o;
	assign receive_data_pin_oe = s.dt_oe;

	property p_disabled_empty;
		@(posedge aclk) disable iff (!aresetn) !s.port_enable |=> s.txs == sp_pkg::TX_IDLE;
	endproperty
	a_disabled_empty: assert property (p_disabled_empty) else $error("shifter busy while port off");
	property p_open_drain;
		@(posedge aclk) disable iff (!aresetn) s.od && $past(s.od) |-> !s.ck_o;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open-drain pin driven high");
	property p_slave_clock;
		@(posedge aclk) disable iff (!aresetn) (s.port_enable && s.sync && !s.clock_source_select) |=> !s.ck_oe;
	endproperty
	a_slave_clock: assert property (p_slave_clock) else $error("slave drives clock pin");
	property p_rx_priority;
		@(posedge aclk) disable iff (!aresetn) (s.port_enable && rx_en) |=> !s.dt_oe;
	endproperty
	a_rx_priority: assert property (p_rx_priority) else $error("data pin driven during receive");
	property p_single_clear;
		@(posedge aclk) disable iff (!aresetn) (rx_done && master) |=> !s.single_receive_enable;
	endproperty
	a_single_clear: assert property (p_single_clear) else $error("single receive not cleared");
	property p_overrun_clear;
		@(posedge aclk) disable iff (!aresetn) (overrun_error_flag_clr && !ovr_set) |=> !s.overrun_error_flag;
	endproperty
	a_overrun_clear: assert property (p_overrun_clear) else $error("overrun not cleared");
	property p_div_restart;
		@(posedge aclk) disable iff (!aresetn) div_wr |=> s.baud_generator == s.div ##1 s.baud_generator != s.div || !s.port_enable || s.div == 8'h00;
	endproperty
	a_div_restart: assert property (p_div_restart) else $error("baud timer not restarted");
	property p_addr_filter;
		@(posedge aclk) disable iff (!aresetn) ($rose(s.rx_full) && !$past(s.sync) && $past(s.rx9) && $past(s.address_detect_enable))
			|-> s.rx_ninth_bit;
	endproperty
	a_addr_filter: assert property (p_addr_filter) else $error("data character passed filter");
	property p_disabled_pins;
		@(posedge aclk) disable iff (!aresetn) !s.port_enable |=> !s.ck_oe && !s.dt_oe;
	endproperty
	a_disabled_pins: assert property (p_disabled_pins) else $error("pins driven while port off");
endmodule // dual_mode_serial_port_ctrl

// ==== tb/serial_peer.sv ====
// Purpose: Far-side serial device for the port bench.
// Assumes: Async bit time of BIT_CYC aclk cycles; released lines pull high.
// Notes: The sync clock it makes runs at 80 ns and stands still between frames.
`timescale 1ns/1ps
module serial_peer #(
	parameter int BIT_CYC = 16
) (
	input wire logic aclk,
	input wire logic ck_wire,
	input wire logic dt_wire,
	output logic dt_drive,
	output logic ck_drive,
	output logic ck_drive_oe
);
	// Idle: data high, own clock released at its pulled-up level.
	initial begin
		dt_drive = 1'b1;
		ck_drive = 1'b1;
		ck_drive_oe = 1'b0;
	end
	// Sends one async frame LSB first; a low stop level makes a framing fault.
	task automatic send_async(input logic [8:0] d, input int nb, input logic stop);
		dt_drive <= 1'b0;
		repeat (BIT_CYC) @(posedge aclk);
		for (int i = 0; i < nb; i++) begin
			dt_drive <= d[i];
			repeat (BIT_CYC) @(posedge aclk);
		end
		dt_drive <= stop;
		repeat (BIT_CYC) @(posedge aclk);
		dt_drive <= 1'b1;
		repeat (2 * BIT_CYC) @(posedge aclk);
	endtask
	// Captures one async frame at mid-bit; a missing frame or stop gives unknowns.
	task automatic recv_async(output logic [8:0] d, input int nb);
		int n;
		n = 0;
		d = 'x;
		while (ck_wire !== 1'b0 && n < 4000) begin
			@(posedge aclk);
			n++;
		end
		if (n < 4000) begin
			d = '0;
			repeat (BIT_CYC / 2) @(posedge aclk);
			for (int i = 0; i < nb; i++) begin
				repeat (BIT_CYC) @(posedge aclk);
				d[i] = ck_wire;
			end
			repeat (BIT_CYC) @(posedge aclk);
			if (ck_wire !== 1'b1) d = 'x;
		end
	endtask
	// Follows the port's shift clock: samples the data line at falls and offers the next bit of s four clocks later.
	task automatic sync_swap(input logic [8:0] s, output logic [8:0] d, input int nb);
		logic prev;
		int n;
		int i;
		d = '0;
		i = 0;
		n = 0;
		prev = ck_wire;
		dt_drive <= s[0];
		while (i < nb && n < 4000) begin
			@(posedge aclk);
			n++;
			if (prev && !ck_wire) begin
				d[i] = dt_wire;
				i++;
				repeat (4) @(posedge aclk);
				if (i < nb) begin
					dt_drive <= s[i];
				end
			end
			prev = ck_wire;
		end
		if (n >= 4000) d = 'x;
		dt_drive <= 1'b1;
	endtask
	// Clocks eight bits into a slave port; data changes at rise, holds over fall.
	// Each half period is four clocks, 80 ns a period, and the clock stands high between frames.
	task automatic clock_out(input logic [7:0] s);
		ck_drive_oe <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			dt_drive <= s[i];
			ck_drive <= 1'b1;
			repeat (4) @(posedge aclk);
			ck_drive <= 1'b0;
			repeat (4) @(posedge aclk);
		end
		ck_drive <= 1'b1;
		repeat (4) @(posedge aclk);
		ck_drive_oe <= 1'b0;
		dt_drive <= 1'b1;
	endtask
endmodule // serial_peer

// ==== tb/dual_mode_serial_port_ctrl_tb.sv ====
// Purpose: Self-checking bench of the serial port over its register bus.
// Assumes: Divisor 0 and high speed give 16 clocks per async bit.
// Notes: Released pins read high, as with a pull-up.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
$display("ERROR %s expected %h seen %h", nm, e, g); end end
module dual_mode_serial_port_ctrl_tb;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr, v;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [8:0] got;
	logic transmit_clock_pin_out, transmit_clock_pin_oe, receive_data_pin_out, receive_data_pin_oe;
	logic ck_drive, ck_drive_oe, dt_drive;
	wire ck_wire;
	wire dt_wire;
	int checked, failures, guard;
	// Each wire takes the port's level when it drives, else the peer or pull-up.
	assign ck_wire = transmit_clock_pin_oe ? transmit_clock_pin_out : (ck_drive_oe ? ck_drive : 1'b1);
	assign dt_wire = receive_data_pin_oe ? receive_data_pin_out : dt_drive;
	dual_mode_serial_port_ctrl dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .transmit_clock_pin_in(ck_wire), .transmit_clock_pin_out,
		.transmit_clock_pin_oe, .receive_data_pin_in(dt_wire), .receive_data_pin_out,
		.receive_data_pin_oe);
	serial_peer #(.BIT_CYC(16)) peer_u (.aclk, .ck_wire, .dt_wire, .dt_drive, .ck_drive, .ck_drive_oe);
	// Clock of 10 ns.
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// One clock with a bound on how long any wait may last.
	task automatic tick();
		@(posedge aclk);
		guard++;
		if (guard > 20000) begin
			failures++;
			complete_run();
		end
	endtask
	// Register write; address and data are released as each is taken.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		guard = 0;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			tick();
			if (awready && !ta) begin
				ta = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !tw) begin
				tw = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid) tick();
		r = bresp;
		bready <= 1'b0;
		tick();
	endtask
	// Register read; data and response are taken at the rvalid edge.
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
		guard = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do tick(); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) tick();
		d = rdata[7:0];
		r = rresp;
		rready <= 1'b0;
		tick();
	endtask
	// Reads a register and compares the bits under the mask.
	task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] d;
		logic [1:0] r;
		rd(a, d, r);
		`CHK(nm, e & m, d & m)
		`CHK("read_resp", sp_pkg::RESP_OKAY, r)
	endtask
	// Sends one async character while the peer listens on the transmit pin.
	task automatic tx_async(input logic [7:0] d, input int nb, input logic [8:0] e);
		logic [7:0] st;
		logic [1:0] r;
		fork
			peer_u.recv_async(got, nb);
			begin
				wr(sp_pkg::OFS_TXD, d, r);
				rd(sp_pkg::OFS_TXCS, st, r);
			end
		join
		`CHK("tx_frame", e, got)
		`CHK("shift_busy", 1'b0, st[1])
		repeat (24) tick();
		rc("shift_empty", sp_pkg::OFS_TXCS, 8'h02, 8'h02);
	endtask
	// Main sequence.
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		checked = 0;
		failures = 0;
		guard = 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		tick();
		rc("txcs_reset", sp_pkg::OFS_TXCS, 8'h02, 8'hFF);
		rc("rxcs_reset", sp_pkg::OFS_RXCS, 8'h00, 8'hFE);
		wr(8'h1C, 8'hFF, rs);
		`CHK("unmapped_resp", sp_pkg::RESP_SLVERR, rs)
		rd(8'h1C, v, rs);
		`CHK("unmapped_rresp", sp_pkg::RESP_SLVERR, rs)
		`CHK("unmapped_rdata", 8'h00, v)
		wr(sp_pkg::OFS_DIV, 8'h00, rs);
		wr(sp_pkg::OFS_RXCS, 8'h90, rs);
		wr(sp_pkg::OFS_TXCS, 8'h24, rs);
		`CHK("tx_oe_push", 1'b1, transmit_clock_pin_oe)
		wr(sp_pkg::OFS_LAT, 8'h80, rs);
		`CHK("tx_oe_open_drain", 1'b0, transmit_clock_pin_oe)
		tx_async(8'hA5, 8, 9'h0A5);
		wr(sp_pkg::OFS_TXCS, 8'h65, rs);
		tx_async(8'h3C, 9, 9'h13C);
		peer_u.send_async(9'h05A, 8, 1'b1);
		rc("rx_full", sp_pkg::OFS_STAT, 8'h01, 8'h01);
		rc("rx_data", sp_pkg::OFS_RXD, 8'h5A, 8'hFF);
		wr(sp_pkg::OFS_RXCS, 8'hD8, rs);
		peer_u.send_async(9'h011, 9, 1'b1);
		rc("addr_drop", sp_pkg::OFS_STAT, 8'h00, 8'h01);
		peer_u.send_async(9'h177, 9, 1'b1);
		rc("addr_ninth", sp_pkg::OFS_RXCS, 8'hD9, 8'hFF);
		rc("addr_data", sp_pkg::OFS_RXD, 8'h77, 8'hFF);
		wr(sp_pkg::OFS_RXCS, 8'h90, rs);
		peer_u.send_async(9'h033, 8, 1'b0);
		rc("framing_error_flag_set", sp_pkg::OFS_RXCS, 8'h94, 8'hFF);
		rd(sp_pkg::OFS_RXD, v, rs);
		peer_u.send_async(9'h044, 8, 1'b1);
		rc("framing_error_flag_clear", sp_pkg::OFS_RXCS, 8'h90, 8'hFF);
		rd(sp_pkg::OFS_RXD, v, rs);
		peer_u.send_async(9'h011, 8, 1'b1);
		peer_u.send_async(9'h022, 8, 1'b1);
		rc("overrun_error_flag_set", sp_pkg::OFS_RXCS, 8'h92, 8'hFF);
		wr(sp_pkg::OFS_RXCS, 8'h80, rs);
		rc("overrun_error_flag_clear", sp_pkg::OFS_RXCS, 8'h80, 8'hFF);
		wr(sp_pkg::OFS_RXCS, 8'h00, rs);
		rc("disable_flush", sp_pkg::OFS_STAT, 8'h00, 8'h01);
		wr(sp_pkg::OFS_DIV, 8'h01, rs);
		wr(sp_pkg::OFS_RXCS, 8'h80, rs);
		wr(sp_pkg::OFS_TXCS, 8'hB0, rs);
		fork
			peer_u.sync_swap(9'h1FF, got, 8);
			begin
				wr(sp_pkg::OFS_TXD, 8'h96, rs);
				`CHK("master_dt_oe", 1'b1, receive_data_pin_oe)
			end
		join
		`CHK("master_frame", 9'h096, got)
		repeat (20) tick();
		fork
			peer_u.sync_swap(9'h0C9, got, 8);
			begin
				wr(sp_pkg::OFS_RXCS, 8'hA0, rs);
				`CHK("rx_over_tx", 1'b0, receive_data_pin_oe)
			end
		join
		repeat (20) tick();
		rc("single_clear", sp_pkg::OFS_RXCS, 8'h80, 8'hFE);
		rc("single_data", sp_pkg::OFS_RXD, 8'hC9, 8'hFF);
		wr(sp_pkg::OFS_TXCS, 8'h10, rs);
		wr(sp_pkg::OFS_RXCS, 8'h90, rs);
		`CHK("slave_ck_oe", 1'b0, transmit_clock_pin_oe)
		peer_u.clock_out(8'h6D);
		repeat (20) tick();
		rc("slave_data", sp_pkg::OFS_RXD, 8'h6D, 8'hFF);
		complete_run();
	end
endmodule // dual_mode_serial_port_ctrl_tb
